// ==== hdl/iap_flash_map.vh ====
// register offsets, field positions, reset values and timing counts for the flash program control
`ifndef IAP_FLASH_MAP_VH
`define IAP_FLASH_MAP_VH
// register indices on the local register port
`define ADDR_FLASH_ADDRESS_LOW 4'h0
`define ADDR_FLASH_ADDRESS_HIGH 4'h1
`define ADDR_FIRST_DATA_LOW 4'h2
`define ADDR_FIRST_DATA_HIGH 4'h3
`define ADDR_SECOND_DATA_LOW 4'h4
`define ADDR_SECOND_DATA_HIGH 4'h5
`define ADDR_THIRD_DATA_LOW 4'h6
`define ADDR_THIRD_DATA_HIGH 4'h7
`define ADDR_FOURTH_DATA_LOW 4'h8
`define ADDR_FOURTH_DATA_HIGH 4'h9
`define ADDR_FLASH_OPERATION_CONTROL 4'ha
`define ADDR_CHIP_RESET_KEY 4'hb
`define ADDR_WRITE_BUFFER_FLUSH 4'hc
// control register fields
`define BIT_ERASE_WRITE_UNLOCKED 7
`define BIT_UNLOCK_TRIGGER 3
`define BIT_PROGRAM_GO 2
`define BIT_READ_ALLOW 1
`define BIT_READ_GO 0
`define OPSEL_HI 6
`define OPSEL_LO 4
// operation select codes
`define OP_WRITE 3'h0
`define OP_ERASE 3'h1
`define OP_READ 3'h3
`define OP_UNLOCK 3'h6
// unlock key bytes, chip reset pattern and register reset value
`define KEY_SECOND_LOW 8'h00
`define KEY_THIRD_LOW 8'h0d
`define KEY_FOURTH_LOW 8'hc3
`define KEY_SECOND_HIGH 8'h04
`define KEY_THIRD_HIGH 8'h09
`define KEY_FOURTH_HIGH 8'h40
`define CHIP_RESET_PATTERN 8'h55
`define REG_RESET 8'h00
// timing
`define CLK_PERIOD_NS 40
`define PROGRAM_TIME_NS 2200000
`define PROGRAM_CYCLES (`PROGRAM_TIME_NS / `CLK_PERIOD_NS)
`define UNLOCK_CYCLES_DEFAULT 1024
`define READ_CYCLES_DEFAULT 4
`define FLUSH_CYCLES 22'h000002
`define CHIP_RESET_CYCLES 5'h10
`endif

// ==== hdl/iap_flash_program_control.v ====
// in-application flash program control: unlock, erase, write, read, buffer flush, chip reset
// Contract
// R1: unlocked bit set only by hardware; software writing one does nothing
// R2: software clearing unlocked bit disables erase and write at once
// R3: operation select: 000 write, 001 erase, 011 read, 110 unlock, rest reserved
// R4: erase or write refused while locked
// R5: erase is block on smallest variant, page on larger ones
// R6: trigger bit starts timer; hardware clears trigger when timer expires
// R7: software writes key into data pairs two to four before timeout
// R8: correct key sets unlocked bit in hardware
// R9: program go starts write or erase; hardware clears it when done
// R10: reads inhibited unless read allow bit is one
// R11: read go starts a read; hardware clears it when done
// R12: software sets program go, read allow, read go by separate writes
// R13: software checks low speed clock stable before erase or write
// R14: cpu halted while started read, erase or write runs
// R15: software waits for completion before next operation
// R16: writing 55h to chip reset key resets the whole chip
// R17: buffer flush bit clears write buffer; hardware clears bit when done
// R18: buffer flush register bits 7 to 1 read zero
// R19: software blank-checks erased words for 0000h and repeats erase
// R20: on failed verify software erases again or flushes and rewrites
// R21: first data high write loads word into buffer, increments address; code holds the address at word 1fh of a page on the larger variant
// R22: key is 00,0d,c3,04,09,40 in low then high of pairs two to four
// R23: write buffer cleared automatically after a write finishes
// R24: erase or write lasts typically 2.2 ms
// R25: unlock timer length parameter; key decides unlocked bit at expiry
// R26: go bit with reserved or mismatched code does nothing and clears at once
`timescale 1ns/1ps
`include "iap_flash_map.vh"
module iap_flash_program_control #(
  parameter LARGE_VARIANT = 1,
  parameter ADDR_WIDTH = 13,
  parameter integer PROGRAM_CYCLES = `PROGRAM_CYCLES,
  parameter integer UNLOCK_CYCLES = `UNLOCK_CYCLES_DEFAULT,
  parameter integer READ_CYCLES = `READ_CYCLES_DEFAULT
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output reg cpu_halt_o,
  output reg chip_reset_o,
  output reg flash_erase_o,
  output reg flash_write_o,
  output reg flash_read_o,
  output reg erase_block_o,
  output reg [ADDR_WIDTH-1:0] flash_addr_o,
  output reg buffer_load_o,
  output reg [15:0] buffer_data_o,
  output reg buffer_clear_o,
  input wire [15:0] flash_rdata_i
);
  localparam ST_IDLE = 2'd0;
  localparam ST_PROG = 2'd1;
  localparam ST_READ = 2'd2;
  localparam ST_FLUSH = 2'd3;

  reg [1:0] state_reg;
  reg [21:0] count_reg;
  reg [15:0] unlock_cnt_reg;
  reg [ADDR_WIDTH-1:0] addr_reg;
  wire [7:0] data_reg [0:7];
  reg unlocked_reg, trigger_reg, prog_go_reg, read_allow_reg, read_go_reg, flush_reg;
  reg [2:0] opsel_reg;
  reg [7:0] reset_key_reg;
  reg [4:0] rst_cnt_reg;
  wire wr_ctrl = wr_en_i && addr_i == `ADDR_FLASH_OPERATION_CONTROL;
  wire [2:0] w_op = wdata_i[`OPSEL_HI:`OPSEL_LO];
  wire read_done = state_reg == ST_READ && count_reg == 22'h000000;
  wire [3:0] data_idx = addr_i - `ADDR_FIRST_DATA_LOW;
  wire key_ok = data_reg[2] == `KEY_SECOND_LOW && data_reg[4] == `KEY_THIRD_LOW &&
    data_reg[6] == `KEY_FOURTH_LOW && data_reg[3] == `KEY_SECOND_HIGH &&
    data_reg[5] == `KEY_THIRD_HIGH && data_reg[7] == `KEY_FOURTH_HIGH; // [R22]
  wire timer_done = trigger_reg && unlock_cnt_reg == 16'h0000;
  wire [7:0] ctrl_val = {unlocked_reg, opsel_reg, trigger_reg, prog_go_reg,
    read_allow_reg, read_go_reg};
  wire [15:0] addr_ext = {{(16-ADDR_WIDTH){1'b0}}, addr_reg};
  wire page_end = LARGE_VARIANT != 0 && addr_reg[4:0] == 5'h1f;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : data_regs
      reg [7:0] byte_reg;
      always @(posedge mclk_i) begin
        if (!rst_n_i)
          byte_reg <= `REG_RESET;
        else if (g < 2 && read_done)
          byte_reg <= flash_rdata_i[8*(g%2) +: 8];
        else if (wr_en_i && {28'h0000000, addr_i} == g + 2)
          byte_reg <= wdata_i;
      end
      assign data_reg[g] = byte_reg;
    end
  endgenerate

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      count_reg <= 22'h000000;
      unlock_cnt_reg <= 16'h0000;
      addr_reg <= {ADDR_WIDTH{1'b0}};
      unlocked_reg <= 1'b0;
      trigger_reg <= 1'b0;
      prog_go_reg <= 1'b0;
      read_allow_reg <= 1'b0;
      read_go_reg <= 1'b0;
      flush_reg <= 1'b0;
      opsel_reg <= 3'h0;
      reset_key_reg <= `REG_RESET;
      rst_cnt_reg <= 5'h00;
      cpu_halt_o <= 1'b0;
      chip_reset_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      flash_read_o <= 1'b0;
      erase_block_o <= 1'b0;
      flash_addr_o <= {ADDR_WIDTH{1'b0}};
      buffer_load_o <= 1'b0;
      buffer_data_o <= 16'h0000;
      buffer_clear_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      buffer_load_o <= 1'b0;
      buffer_clear_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      flash_read_o <= 1'b0;
      erase_block_o <= (LARGE_VARIANT == 0); // [R5]
      flash_addr_o <= addr_reg;
      // register writes
      if (wr_en_i && addr_i == `ADDR_FLASH_ADDRESS_LOW)
        addr_reg[7:0] <= wdata_i;
      if (wr_en_i && addr_i == `ADDR_FLASH_ADDRESS_HIGH)
        addr_reg[ADDR_WIDTH-1:8] <= wdata_i[ADDR_WIDTH-9:0];
      if (wr_en_i && addr_i == `ADDR_FIRST_DATA_HIGH) begin
        buffer_load_o <= 1'b1; // [R21]
        buffer_data_o <= {wdata_i, data_reg[0]};
        if (!page_end)
          addr_reg <= addr_reg + 1'b1; // [R21]
      end
      if (wr_en_i && addr_i == `ADDR_CHIP_RESET_KEY) begin
        reset_key_reg <= wdata_i;
        if (wdata_i == `CHIP_RESET_PATTERN)
          rst_cnt_reg <= `CHIP_RESET_CYCLES; // [R16]
      end
      if (rst_cnt_reg != 5'h00)
        rst_cnt_reg <= rst_cnt_reg - 1'b1;
      chip_reset_o <= rst_cnt_reg != 5'h00; // [R16]
      if (wr_en_i && addr_i == `ADDR_WRITE_BUFFER_FLUSH && wdata_i[0] &&
          LARGE_VARIANT != 0 && state_reg == ST_IDLE) begin
        flush_reg <= 1'b1; // [R17]
        state_reg <= ST_FLUSH;
        count_reg <= `FLUSH_CYCLES;
        buffer_clear_o <= 1'b1;
      end
      if (wr_ctrl) begin
        opsel_reg <= w_op; // [R3]
        read_allow_reg <= wdata_i[`BIT_READ_ALLOW];
        if (!wdata_i[`BIT_ERASE_WRITE_UNLOCKED])
          unlocked_reg <= 1'b0; // [R1] [R2]
        if (wdata_i[`BIT_UNLOCK_TRIGGER] && !trigger_reg && w_op == `OP_UNLOCK) begin
          trigger_reg <= 1'b1; // [R6]
          unlock_cnt_reg <= UNLOCK_CYCLES[15:0];
        end
        if (state_reg == ST_IDLE && wdata_i[`BIT_PROGRAM_GO]) begin
          if ((w_op == `OP_WRITE || w_op == `OP_ERASE) && unlocked_reg &&
              wdata_i[`BIT_ERASE_WRITE_UNLOCKED]) begin // [R4] [R2] [R26]
            prog_go_reg <= 1'b1; // [R9]
            state_reg <= ST_PROG;
            count_reg <= PROGRAM_CYCLES[21:0]; // [R24]
            cpu_halt_o <= 1'b1; // [R14]
            flash_erase_o <= w_op == `OP_ERASE;
            flash_write_o <= w_op == `OP_WRITE;
          end
        end else if (state_reg == ST_IDLE && wdata_i[`BIT_READ_GO]) begin
          if (w_op == `OP_READ && read_allow_reg) begin // [R10]
            read_go_reg <= 1'b1; // [R11]
            state_reg <= ST_READ;
            count_reg <= READ_CYCLES[21:0];
            cpu_halt_o <= 1'b1; // [R14]
            flash_read_o <= 1'b1;
          end
        end
      end
      // unlock timer and key decision
      if (trigger_reg) begin
        if (timer_done) begin
          trigger_reg <= 1'b0; // [R6]
          if (key_ok && !(wr_ctrl && !wdata_i[`BIT_ERASE_WRITE_UNLOCKED]))
            unlocked_reg <= 1'b1; // [R8] [R25]
        end else
          unlock_cnt_reg <= unlock_cnt_reg - 1'b1;
      end
      // operation sequencer
      case (state_reg)
        ST_IDLE: begin
        end
        ST_PROG, ST_READ, ST_FLUSH: begin
          if (count_reg != 22'h000000)
            count_reg <= count_reg - 1'b1;
          else begin
            state_reg <= ST_IDLE;
            cpu_halt_o <= 1'b0;
            if (state_reg == ST_PROG && prog_go_reg) begin
              prog_go_reg <= 1'b0; // [R9]
              buffer_clear_o <= opsel_reg == `OP_WRITE; // [R23]
            end
            if (state_reg == ST_READ) begin
              read_go_reg <= 1'b0; // [R11]
            end
            if (state_reg == ST_FLUSH)
              flush_reg <= 1'b0; // [R17]
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // register reads
      if (rd_en_i) begin
        case (addr_i)
          `ADDR_FLASH_ADDRESS_LOW: rdata_o <= addr_reg[7:0];
          `ADDR_FLASH_ADDRESS_HIGH: rdata_o <= addr_ext[15:8];
          `ADDR_FLASH_OPERATION_CONTROL: rdata_o <= ctrl_val;
          `ADDR_CHIP_RESET_KEY: rdata_o <= reset_key_reg;
          `ADDR_WRITE_BUFFER_FLUSH: rdata_o <= {7'h00, flush_reg}; // [R18]
          default: rdata_o <= (addr_i <= `ADDR_FOURTH_DATA_HIGH) ?
            data_reg[data_idx[2:0]] : 8'h00;
        endcase
      end
    end
  end
endmodule // iap_flash_program_control

// ==== verif/iap_flash_program_control_monitor.sv ====
// port checker for the flash program control
`timescale 1ns/1ps
module iap_flash_program_control_monitor #(
  parameter LARGE_VARIANT = 1,
  parameter integer PROGRAM_CYCLES = 20
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire wr_en_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire cpu_halt_o,
  input wire chip_reset_o,
  input wire flash_erase_o,
  input wire flash_write_o,
  input wire flash_read_o,
  input wire erase_block_o,
  input wire buffer_load_o,
  input wire [15:0] buffer_data_o,
  input wire buffer_clear_o
);
  localparam int PL = PROGRAM_CYCLES - 2;
  localparam int PH = PROGRAM_CYCLES + 6;
  wire start = flash_erase_o || flash_write_o || flash_read_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_halt; start |-> cpu_halt_o; endproperty
  a_halt: assert property (p_halt) else $error("no halt at start");
  property p_halt_cause; $rose(cpu_halt_o) |-> start; endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without start");
  property p_prog_span; flash_erase_o || flash_write_o |=> cpu_halt_o [*8]; endproperty
  a_prog_span: assert property (p_prog_span) else $error("program ended early");
  property p_clear; flash_write_o |-> ##[PL:PH] buffer_clear_o; endproperty
  a_clear: assert property (p_clear) else $error("no buffer clear");
  property p_kind; flash_erase_o |-> erase_block_o == (LARGE_VARIANT == 0); endproperty
  a_kind: assert property (p_kind) else $error("erase kind");
  property p_load;
    wr_en_i && addr_i == 4'h3 |=> buffer_load_o && buffer_data_o[15:8] == $past(wdata_i);
  endproperty
  a_load: assert property (p_load) else $error("buffer load");
  property p_key; wr_en_i && addr_i == 4'hb && wdata_i == 8'h55 |-> ##[1:20] chip_reset_o; endproperty
  a_key: assert property (p_key) else $error("no chip reset");
  property p_resv;
    wr_en_i && addr_i == 4'ha && wdata_i[6:4] inside {3'h2, 3'h4, 3'h5, 3'h7} |=> !start [*3];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved code acted");
endmodule // iap_flash_program_control_monitor
bind iap_flash_program_control iap_flash_program_control_monitor #(
  .LARGE_VARIANT(LARGE_VARIANT), .PROGRAM_CYCLES(PROGRAM_CYCLES)) i_mon (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .cpu_halt_o(cpu_halt_o), .chip_reset_o(chip_reset_o), .flash_erase_o(flash_erase_o),
  .flash_write_o(flash_write_o), .flash_read_o(flash_read_o), .erase_block_o(erase_block_o),
  .buffer_load_o(buffer_load_o), .buffer_data_o(buffer_data_o), .buffer_clear_o(buffer_clear_o));

// ==== verif/iap_flash_array_model.sv ====
// flash array model answering read starts with an address-derived word, or zero on the last erased page until a write starts
`timescale 1ns/1ps
module iap_flash_array_model (
  input wire mclk_i,
  input wire rd_start_i,
  input wire erase_start_i,
  input wire write_start_i,
  input wire [12:0] addr_i,
  output reg [15:0] rdata_o
);
  reg [7:0] erased_page = 8'h00;
  reg erased = 1'b0;
  initial rdata_o = 16'h0000;
  always @(posedge mclk_i) begin
    if (erase_start_i) begin
      erased <= 1'b1;
      erased_page <= addr_i[12:5];
    end
    if (write_start_i)
      erased <= 1'b0;
    if (rd_start_i)
      rdata_o <= (erased && addr_i[12:5] == erased_page) ? 16'h0000 :
        {3'h0, addr_i} ^ 16'h5a3c;
  end
endmodule // iap_flash_array_model

// ==== verif/iap_flash_program_control_bench.sv ====
// self-checking bench for the flash program control
`timescale 1ns/1ps
`include "iap_flash_map.vh"
module iap_flash_program_control_bench;
  localparam [3:0] CT = `ADDR_FLASH_OPERATION_CONTROL;
  reg mclk_i = 0, rst_n_i = 0, wr_en_i = 0, rd_en_i = 0;
  reg [3:0] addr_i = 0;
  reg [7:0] wdata_i = 0, v, r;
  wire [7:0] rdata_o;
  wire cpu_halt_o, chip_reset_o, flash_erase_o, flash_write_o, flash_read_o, erase_block_o;
  wire buffer_load_o, buffer_clear_o;
  wire [12:0] flash_addr_o;
  wire [15:0] buffer_data_o, flash_rdata_i;
  int n_mismatch = 0, n_tests = 0, cyc = 0, ea = 0;
  reg [31:0] seed = 32'h88f8f6cc;
  reg [7:0] key [6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
  iap_flash_program_control #(.PROGRAM_CYCLES(20), .UNLOCK_CYCLES(32))
  i_iap_flash_program_control (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .cpu_halt_o(cpu_halt_o), .chip_reset_o(chip_reset_o),
    .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o), .flash_read_o(flash_read_o),
    .erase_block_o(erase_block_o), .flash_addr_o(flash_addr_o), .buffer_load_o(buffer_load_o),
    .buffer_data_o(buffer_data_o), .buffer_clear_o(buffer_clear_o), .flash_rdata_i(flash_rdata_i));
  iap_flash_array_model i_iap_flash_array_model (.mclk_i(mclk_i), .rd_start_i(flash_read_o),
    .erase_start_i(flash_erase_o), .write_start_i(flash_write_o),
    .addr_i(flash_addr_o), .rdata_o(flash_rdata_i));
  initial forever #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      close_out;
    end
  end
  function [7:0] xs;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed[7:0];
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge mclk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_en_i <= 1'b0;
    #1;
  endtask
  task rd(input [3:0] a);
    @(posedge mclk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_en_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task go(input [7:0] d);
    wr(CT, d);
    @(posedge mclk_i);
    #1;
  endtask
  task idle;
    repeat (60) if (cpu_halt_o === 1'b1) begin
      @(posedge mclk_i);
      #1;
    end
    chk(cpu_halt_o, 0);
  endtask
  task unlock(input [7:0] last);
    wr(CT, 8'h68);
    for (int i = 0; i < 6; i++) wr(4'h4 + i[3:0], i == 5 ? last : key[i]);
    repeat (40) @(posedge mclk_i);
    rd(CT);
  endtask
  task close_out;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int a = 8; a < 13; a++) begin
      rd(a[3:0]);
      chk(v, `REG_RESET);
    end
    r = xs();
    wr(`ADDR_FOURTH_DATA_HIGH, r);
    rd(`ADDR_FOURTH_DATA_HIGH);
    chk(v, r);
    wr(CT, 8'h80);
    rd(CT);
    chk(v, 8'h00);
    go(8'h94);
    chk(cpu_halt_o, 0);
    rd(CT);
    chk(v, 8'h10);
    unlock(8'h41);
    chk(v, 8'h60);
    unlock(8'h40);
    chk(v, 8'he0);
    for (int c = 2; c < 8; c++) if (c != 3 && c != 6) begin
      go(8'h84 | (c[7:0] << 4));
      chk(cpu_halt_o, 0);
    end
    go(8'h94);
    chk(cpu_halt_o, 1);
    idle;
    rd(CT);
    chk(v, 8'h90);
    wr(CT, 8'hb2);
    go(8'hb3);
    idle;
    rd(`ADDR_FIRST_DATA_HIGH);
    r = v;
    rd(`ADDR_FIRST_DATA_LOW);
    chk({r, v}, 16'h0000);
    wr(`ADDR_FLASH_ADDRESS_LOW, 8'h1e);
    wr(`ADDR_FLASH_ADDRESS_HIGH, 8'h00);
    ea = 'h1e;
    for (int i = 0; i < 2; i++) begin
      r = xs();
      wr(`ADDR_FIRST_DATA_LOW, r);
      v = xs();
      wr(`ADDR_FIRST_DATA_HIGH, v);
      chk(buffer_data_o, {v, r});
      if (ea % 32 != 31) ea++;
      @(posedge mclk_i);
      #1;
      chk(flash_addr_o, ea[15:0]);
    end
    go(8'h84);
    chk(cpu_halt_o, 1);
    idle;
    rd(CT);
    chk(v, 8'h80);
    go(8'h14);
    chk(cpu_halt_o, 0);
    wr(`ADDR_FLASH_ADDRESS_LOW, 8'h40);
    go(8'h31);
    chk(cpu_halt_o, 0);
    wr(CT, 8'h32);
    go(8'h33);
    chk(cpu_halt_o, 1);
    idle;
    rd(`ADDR_FIRST_DATA_HIGH);
    r = v;
    rd(`ADDR_FIRST_DATA_LOW);
    chk({r, v}, 16'h0040 ^ 16'h5a3c);
    wr(`ADDR_WRITE_BUFFER_FLUSH, 8'hff);
    rd(`ADDR_WRITE_BUFFER_FLUSH);
    chk(v, 8'h01);
    repeat (5) @(posedge mclk_i);
    rd(`ADDR_WRITE_BUFFER_FLUSH);
    chk(v, 8'h00);
    wr(`ADDR_CHIP_RESET_KEY, 8'h55);
    repeat (20) if (chip_reset_o !== 1'b1) begin
      @(posedge mclk_i);
      #1;
    end
    chk(chip_reset_o, 1);
    close_out;
  end
endmodule // iap_flash_program_control_bench
